// ===== ccl_analog_model.sv
// behavioural analog comparator core with its input multiplexer
// assumes pin voltages in millivolts come from the testbench
`timescale 1ns/100ps
module ccl_analog_model
(
   input wire logic cmp_enable,
   input wire logic [2:0] pos_input_sel,
   input wire logic [2:0] neg_input_sel,
   input wire logic response_speed_sel,
   input var int pin_mv [8],
   output logic cmp_raw
);
   int vp;
   int vn;

   // settled low level before the first response delay has run out
   initial cmp_raw = 1'b0;

   // even pins feed pos_input, odd pins neg_input; 1xx leaves it open
   always_comb
   begin
      vp = pos_input_sel[2] ? 0 : pin_mv[2 * pos_input_sel[1:0]];
      vn = neg_input_sel[2] ? 0 : pin_mv[2 * neg_input_sel[1:0] + 1];
   end

   // result lags the inputs by the selected response time; an unpowered
   // core is not trusted, so it keeps moving even while disabled
   always @(vp or vn or cmp_enable)
      cmp_raw <= #(response_speed_sel ? 40 : 750) (vp > vn);
endmodule

// ===== ccl_comparator_ctrl.sv
// register block and control logic around the analog comparator core
// assumes a single-cycle register bus from the processor on ref_clk,
// and an analog core that takes the forwarded codes as static levels
`timescale 1ns/100ps
`include "ccl_map.svh"

// Overview of operation
// - control bit 7 powers the comparator; writing zero disables it.
// - read-only result bit 6 shows positive input above negative input.
// - enabled comparator with low result requests oscillator wake-up.
// - each rising result transition while enabled sets the rising flag.
// - each falling result transition while enabled sets the falling flag.
// - positive hysteresis code bits 3:2 go to the analog core.
// - negative hysteresis code bits 1:0 go to the analog core.
// - mode bit 5 lets rising events raise the interrupt.
// - mode bit 4 lets falling events raise the interrupt.
// - mode bit 0 picks slow low-power or fast response.
// - mode bit 7 selects high-speed analog input mode.
// - negative select codes 0-3 pick odd pins; top bit set picks none.
// - positive select codes 0-3 pick even pins; top bit set picks none.
// - comparator interrupt wakes from stop mode without the clock.
// - flags stay set until software clears them.
// - pin output of a disabled comparator is driven low.
module ccl_comparator_ctrl
   import ccl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic cmp_raw,
   output logic cmp_enable,
   output logic [1:0] pos_hyst_code,
   output logic [1:0] neg_hyst_code,
   output logic response_speed_sel,
   output logic fast_analog_input,
   output logic [2:0] neg_input_sel,
   output logic [2:0] pos_input_sel,
   output logic irq_req,
   output logic osc_wake,
   output logic stop_wake,
   output logic cmp_pin_out
);

   ccl_edge_if edge_c ();

   logic enable_q;
   logic rise_flag_q;
   logic fall_flag_q;
   logic [1:0] pos_hyst_q;
   logic [1:0] neg_hyst_q;
   logic fast_in_q;
   logic rise_ie_q;
   logic fall_ie_q;
   logic speed_q;
   logic [2:0] neg_sel_q;
   logic [2:0] pos_sel_q;
   ccl_byte_t rdata_q;
   logic irq_q;
   logic osc_wake_q;
   logic stop_wake_q;
   logic pin_out_q;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_mux;
   logic wake_set;
   ccl_byte_t ctrl_view;
   ccl_byte_t mode_view;
   ccl_byte_t mux_view;
   // reset image of the input select register, sliced per field below
   localparam ccl_byte_t mux_reset = `CCL_RST_MUX;

   // map a bus address onto one of the three registers
   function automatic ccl_reg_e reg_decode(input logic [7:0] addr);
      ccl_reg_e sel;
      case (addr)
         `CCL_ADDR_CTRL: sel = CCL_REG_CTRL;
         `CCL_ADDR_MODE: sel = CCL_REG_MODE;
         `CCL_ADDR_MUX: sel = CCL_REG_MUX;
         default: sel = CCL_REG_NONE;
      endcase
      return sel;
   endfunction

   // synchronised result and edge pulses
   ccl_edge_det u_edge (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cmp_raw(cmp_raw),
      .enable(enable_q),
      .edge_o(edge_c.producer)
   );

   // write strobes per register
   assign wr_ctrl = sfr_wr && (reg_decode(sfr_addr) == CCL_REG_CTRL);
   assign wr_mode = sfr_wr && (reg_decode(sfr_addr) == CCL_REG_MODE);
   assign wr_mux = sfr_wr && (reg_decode(sfr_addr) == CCL_REG_MUX);

   // enable and hysteresis codes
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         enable_q <= 1'(`CCL_RST_CTRL >> `CCL_CTRL_EN);
         pos_hyst_q <= 2'h0;
         neg_hyst_q <= 2'h0;
      end
      else if (wr_ctrl)
      begin
         enable_q <= sfr_wdata[`CCL_CTRL_EN];
         pos_hyst_q <= sfr_wdata[`CCL_CTRL_HYP_HI:`CCL_CTRL_HYP_LO];
         neg_hyst_q <= sfr_wdata[`CCL_CTRL_HYN_HI:`CCL_CTRL_HYN_LO];
      end
   end

   // rising flag: hardware set wins over a software write of zero
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         rise_flag_q <= 1'b0;
      else if (edge_c.rise)
         rise_flag_q <= 1'b1;
      else if (wr_ctrl)
         rise_flag_q <= sfr_wdata[`CCL_CTRL_RISE];
   end

   // falling flag: hardware set wins over a software write of zero
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         fall_flag_q <= 1'b0;
      else if (edge_c.fall)
         fall_flag_q <= 1'b1;
      else if (wr_ctrl)
         fall_flag_q <= sfr_wdata[`CCL_CTRL_FALL];
   end

   // mode register
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         fast_in_q <= 1'b0;
         rise_ie_q <= 1'b0;
         fall_ie_q <= 1'b0;
         speed_q <= 1'b0;
      end
      else if (wr_mode)
      begin
         fast_in_q <= sfr_wdata[`CCL_MODE_FAST_IN];
         rise_ie_q <= sfr_wdata[`CCL_MODE_RISE_IE];
         fall_ie_q <= sfr_wdata[`CCL_MODE_FALL_IE];
         speed_q <= sfr_wdata[`CCL_MODE_SPEED];
      end
   end

   // input select register; codes with top bit set select no pin
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         neg_sel_q <= mux_reset[`CCL_MUX_NEG_HI:`CCL_MUX_NEG_LO];
         pos_sel_q <= mux_reset[`CCL_MUX_POS_HI:`CCL_MUX_POS_LO];
      end
      else if (wr_mux)
      begin
         neg_sel_q <= sfr_wdata[`CCL_MUX_NEG_HI:`CCL_MUX_NEG_LO];
         pos_sel_q <= sfr_wdata[`CCL_MUX_POS_HI:`CCL_MUX_POS_LO];
      end
   end

   // read views; unused bits read zero
   assign ctrl_view = {enable_q, edge_c.sample, rise_flag_q, fall_flag_q,
                       pos_hyst_q, neg_hyst_q};
   assign mode_view = {fast_in_q, 1'b0, rise_ie_q, fall_ie_q, 3'h0,
                       speed_q} & `CCL_MODE_MASK;
   assign mux_view = {1'b0, neg_sel_q, 1'b0, pos_sel_q} & `CCL_MUX_MASK;

   // registered read data, zero for unmapped addresses or idle bus
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         rdata_q <= 8'h00;
      else if (sfr_rd)
      begin
         case (reg_decode(sfr_addr))
            CCL_REG_CTRL: rdata_q <= ctrl_view;
            CCL_REG_MODE: rdata_q <= mode_view;
            CCL_REG_MUX: rdata_q <= mux_view;
            default: rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   // interrupt request from flags gated by their enables
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         irq_q <= 1'b0;
      else
         irq_q <= (rise_flag_q & rise_ie_q)
                  | (fall_flag_q & fall_ie_q);
   end

   // oscillator wake while enabled and the result is low
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         osc_wake_q <= 1'b0;
      else
         osc_wake_q <= enable_q & ~edge_c.sample;
   end

   // pin output forced low while disabled
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         pin_out_q <= 1'b0;
      else
         pin_out_q <= enable_q & edge_c.sample;
   end

   // stop-mode wake: the raw result differing from the last sample in
   // an enabled direction sets the flop with no clock edge; once the
   // clock runs again the sample catches up and the request drops
   assign wake_set = enable_q & ((rise_ie_q & cmp_raw & ~edge_c.sample)
                     | (fall_ie_q & ~cmp_raw & edge_c.sample));

   always_ff @(posedge ref_clk or posedge wake_set)
   begin
      if (wake_set)
         stop_wake_q <= 1'b1;
      else if (!reset_n)
         stop_wake_q <= 1'b0;
      else
         stop_wake_q <= 1'b0;
   end

   // outputs straight from flip-flops
   assign sfr_rdata = rdata_q;
   assign cmp_enable = enable_q;
   assign pos_hyst_code = pos_hyst_q;
   assign neg_hyst_code = neg_hyst_q;
   assign response_speed_sel = speed_q;
   assign fast_analog_input = fast_in_q;
   assign neg_input_sel = neg_sel_q;
   assign pos_input_sel = pos_sel_q;
   assign irq_req = irq_q;
   assign osc_wake = osc_wake_q;
   assign stop_wake = stop_wake_q;
   assign cmp_pin_out = pin_out_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_enable_write: assert property (wr_ctrl |=>
      cmp_enable == $past(sfr_wdata[`CCL_CTRL_EN]))
      else $error("enable bit did not follow the write");
   a_result_read: assert property (sfr_rd && !sfr_wr
      && reg_decode(sfr_addr) == CCL_REG_CTRL |=>
      sfr_rdata[`CCL_CTRL_RESULT] == $past(edge_c.sample))
      else $error("result bit read back wrong");
   a_osc_wake_low: assert property (enable_q && !edge_c.sample
      |=> osc_wake)
      else $error("oscillator wake missing while result is low");
   a_rise_flag_set: assert property (edge_c.rise |=> rise_flag_q)
      else $error("rising edge did not set its flag");
   a_fall_flag_set: assert property (edge_c.fall |=> fall_flag_q)
      else $error("falling edge did not set its flag");
   a_hyst_forward: assert property (wr_ctrl |=>
      {pos_hyst_code, neg_hyst_code} == $past(sfr_wdata[3:0]))
      else $error("hysteresis codes not forwarded");
   a_mode_forward: assert property (wr_mode |=>
      {fast_analog_input, rise_ie_q, fall_ie_q, response_speed_sel}
      == {$past(sfr_wdata[`CCL_MODE_FAST_IN]),
      $past(sfr_wdata[`CCL_MODE_RISE_IE]),
      $past(sfr_wdata[`CCL_MODE_FALL_IE]),
      $past(sfr_wdata[`CCL_MODE_SPEED])})
      else $error("mode bits not forwarded");
   a_mux_forward: assert property (wr_mux |=>
      {neg_input_sel, pos_input_sel}
      == {$past(sfr_wdata[6:4]), $past(sfr_wdata[2:0])})
      else $error("input select not forwarded");
   a_flag_sticky: assert property ($fell(rise_flag_q) |->
      $past(wr_ctrl) && !$past(sfr_wdata[`CCL_CTRL_RISE]))
      else $error("rising flag cleared without a software write");
   a_fall_sticky: assert property ($fell(fall_flag_q) |->
      $past(wr_ctrl) && !$past(sfr_wdata[`CCL_CTRL_FALL]))
      else $error("falling flag cleared without a software write");
   a_irq_gating: assert property (rise_flag_q && rise_ie_q
      |=> irq_req)
      else $error("interrupt missing for enabled rising flag");
   a_irq_fall_gating: assert property (fall_flag_q && fall_ie_q
      |=> irq_req)
      else $error("interrupt missing for enabled falling flag");
   a_irq_cause: assert property (irq_req |->
      $past(rise_flag_q && rise_ie_q || fall_flag_q && fall_ie_q))
      else $error("interrupt without an enabled flag");
   a_pin_low_off: assert property (!enable_q |=> !cmp_pin_out)
      else $error("pin output high while disabled");

   c_rise_irq: cover property (edge_c.rise && rise_ie_q ##2 irq_req);
   c_fall_irq: cover property (edge_c.fall && fall_ie_q ##2 irq_req);
   c_set_over_clear: cover property (edge_c.rise && wr_ctrl);
   c_stop_wake: cover property (stop_wake);

endmodule

// ===== ccl_edge_det.sv
// synchroniser and edge detector for the raw comparator output
// assumes cmp_raw is asynchronous to ref_clk
`timescale 1ns/100ps
module ccl_edge_det
   import ccl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cmp_raw,
   input wire logic enable,
   ccl_edge_if.producer edge_o
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // two-stage synchroniser, first stage read only by the second
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= cmp_raw;
         sync_q <= meta_q;
      end
   end

   // previous synchronised sample for comparison
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         last_q <= 1'b0;
      else
         last_q <= sync_q;
   end

   // edges count only while the comparator is powered
   assign edge_o.sample = sync_q;
   assign edge_o.rise = enable & sync_q & ~last_q;
   assign edge_o.fall = enable & ~sync_q & last_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_rise_single: assert property (edge_o.rise |=> !edge_o.rise)
      else $error("rising pulse lasted more than one cycle");
   a_fall_single: assert property (edge_o.fall |=> !edge_o.fall)
      else $error("falling pulse lasted more than one cycle");
   a_edge_cause: assert property (edge_o.rise |->
      sync_q && $past(sync_q) == 1'b0)
      else $error("rising pulse without a synchronised transition");

endmodule

// ===== ccl_edge_if.sv
// carrier between the edge detector and the register block
// assumes both ends run on ref_clk
`timescale 1ns/100ps
interface ccl_edge_if;
   logic sample; // synchronised comparator result
   logic rise;   // one-cycle pulse per rising transition while enabled
   logic fall;   // one-cycle pulse per falling transition while enabled

   modport producer (output sample, output rise, output fall);
   modport consumer (input sample, input rise, input fall);
endinterface

// ===== ccl_map.svh
// register map, field positions and reset values of the comparator
// control logic; included by every file that decodes the registers
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH

// register addresses in the processor's register space
`define CCL_ADDR_CTRL 8'h9B
`define CCL_ADDR_MODE 8'h9D
`define CCL_ADDR_MUX 8'h9F

// reset values
`define CCL_RST_CTRL 8'h00
`define CCL_RST_MODE 8'h00
`define CCL_RST_MUX 8'h44

// control register fields
`define CCL_CTRL_EN 7
`define CCL_CTRL_RESULT 6
`define CCL_CTRL_RISE 5
`define CCL_CTRL_FALL 4
`define CCL_CTRL_HYP_HI 3
`define CCL_CTRL_HYP_LO 2
`define CCL_CTRL_HYN_HI 1
`define CCL_CTRL_HYN_LO 0

// mode register fields
`define CCL_MODE_FAST_IN 7
`define CCL_MODE_RISE_IE 5
`define CCL_MODE_FALL_IE 4
`define CCL_MODE_SPEED 0
`define CCL_MODE_MASK 8'hB1

// input select register fields
`define CCL_MUX_NEG_HI 6
`define CCL_MUX_NEG_LO 4
`define CCL_MUX_POS_HI 2
`define CCL_MUX_POS_LO 0
`define CCL_MUX_MASK 8'h77

`endif

// ===== ccl_pkg.sv
// types shared by the comparator control logic
// assumes ccl_map.svh holds the numeric constants
package ccl_pkg;

   typedef logic [7:0] ccl_byte_t;

   // which register an address selects
   typedef enum {CCL_REG_CTRL, CCL_REG_MODE, CCL_REG_MUX,
                 CCL_REG_NONE} ccl_reg_e;

endpackage

// ===== tb_comparator_control_logic.sv
// self-checking bench for the comparator control logic
// assumes the analog model turns pin voltages into cmp_raw
`timescale 1ns/100ps
`include "ccl_map.svh"
`define CHK(got, exp) \
   begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR %0t got %h want %h", $time, got, exp); end end
module tb_comparator_control_logic
   import ccl_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   ccl_byte_t sfr_addr = 8'h00;
   ccl_byte_t sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   ccl_byte_t sfr_rdata;
   logic cmp_raw, cmp_enable, response_speed_sel, fast_analog_input;
   logic [1:0] pos_hyst_code, neg_hyst_code;
   logic [2:0] neg_input_sel, pos_input_sel;
   logic irq_req, osc_wake, stop_wake, cmp_pin_out;
   int pin_mv [8] = '{default: 100};
   int error_cnt = 0;
   int checks = 0;

   // 40 MHz system clock
   always #12.5 ref_clk = ~ref_clk;

   ccl_comparator_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw),
      .cmp_enable(cmp_enable), .pos_hyst_code(pos_hyst_code),
      .neg_hyst_code(neg_hyst_code),
      .response_speed_sel(response_speed_sel),
      .fast_analog_input(fast_analog_input),
      .neg_input_sel(neg_input_sel), .pos_input_sel(pos_input_sel),
      .irq_req(irq_req), .osc_wake(osc_wake), .stop_wake(stop_wake),
      .cmp_pin_out(cmp_pin_out));

   ccl_analog_model ana (.cmp_enable(cmp_enable),
      .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
      .response_speed_sel(response_speed_sel), .pin_mv(pin_mv),
      .cmp_raw(cmp_raw));

   // one-cycle write strobe, launched at the falling edge
   task automatic wr(input ccl_byte_t a, input ccl_byte_t d);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask

   // one-cycle read strobe; data stands for the cycle after the edge
   task automatic rd(input ccl_byte_t a, input ccl_byte_t exp);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      `CHK(sfr_rdata, exp)
   endtask

   // covers the slow response time plus the synchroniser
   task automatic settle;
      repeat (40) @(negedge ref_clk);
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // bounded wait for the interrupt request to reach a level
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (irq_req !== lvl && n < 10)
      begin
         @(negedge ref_clk);
         n++;
      end
      `CHK(irq_req, lvl)
      if (irq_req !== lvl)
         finish_test();
   endtask

   // main sequence
   initial
   begin
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      rd(`CCL_ADDR_CTRL, `CCL_RST_CTRL);
      rd(`CCL_ADDR_MODE, `CCL_RST_MODE);
      rd(`CCL_ADDR_MUX, `CCL_RST_MUX);
      `CHK(pos_input_sel, 3'b100)
      wr(8'h9C, 8'hFF);
      rd(8'h9C, 8'h00);
      wr(`CCL_ADDR_MODE, 8'hFF);
      rd(`CCL_ADDR_MODE, 8'hB1);
      `CHK(fast_analog_input, 1'b1)
      `CHK(response_speed_sel, 1'b1)
      wr(`CCL_ADDR_MUX, 8'hFF);
      rd(`CCL_ADDR_MUX, 8'h77);
      `CHK(neg_input_sel, 3'h7)
      for (int c = 0; c < 4; c++)
      begin
         wr(`CCL_ADDR_MUX, {1'b0, 3'(c), 1'b0, 3'(3 - c)});
         `CHK(neg_input_sel, 3'(c))
         `CHK(pos_input_sel, 3'(3 - c))
         wr(`CCL_ADDR_CTRL, {4'h0, 2'(c), 2'(3 - c)});
         `CHK(pos_hyst_code, 2'(c))
         `CHK(neg_hyst_code, 2'(3 - c))
      end
      // enable with pos below neg, fast response, flags cleared
      pin_mv[1] = 200;
      wr(`CCL_ADDR_MUX, 8'h00);
      wr(`CCL_ADDR_MODE, 8'h01);
      `CHK(response_speed_sel, 1'b1)
      wr(`CCL_ADDR_CTRL, 8'h80);
      settle();
      `CHK(cmp_enable, 1'b1)
      `CHK(osc_wake, 1'b1)
      wr(`CCL_ADDR_CTRL, 8'h80);
      rd(`CCL_ADDR_CTRL, 8'h80);
      // rising edge with its interrupt enabled
      wr(`CCL_ADDR_MODE, 8'h21);
      pin_mv[0] = 300;
      #45;
      `CHK(stop_wake, 1'b1)
      settle();
      rd(`CCL_ADDR_CTRL, 8'hE0);
      `CHK(irq_req, 1'b1)
      `CHK(osc_wake, 1'b0)
      `CHK(cmp_pin_out, 1'b1)
      `CHK(stop_wake, 1'b0)
      rd(`CCL_ADDR_CTRL, 8'hE0);
      wr(`CCL_ADDR_MODE, 8'h01);
      wait_irq(1'b0);
      // clearing with a steady result must not set the flag again
      wr(`CCL_ADDR_CTRL, 8'h80);
      settle();
      rd(`CCL_ADDR_CTRL, 8'hC0);
      // falling edge, blocked and then allowed
      pin_mv[0] = 100;
      settle();
      rd(`CCL_ADDR_CTRL, 8'h90);
      `CHK(irq_req, 1'b0)
      wr(`CCL_ADDR_MODE, 8'h11);
      wait_irq(1'b1);
      wr(`CCL_ADDR_CTRL, 8'h80);
      wait_irq(1'b0);
      // disabled: pin output low and edges ignored
      wr(`CCL_ADDR_CTRL, 8'h00);
      `CHK(cmp_enable, 1'b0)
      pin_mv[0] = 300;
      settle();
      `CHK(cmp_pin_out, 1'b0)
      `CHK(osc_wake, 1'b0)
      pin_mv[0] = 100;
      settle();
      rd(`CCL_ADDR_CTRL, 8'h00);
      finish_test();
   end
endmodule
